// ===== design/adc_cmd_pkg.sv
package adc_cmd_pkg;

    // Sweep modes of a conversion command
    typedef enum logic [1:0] {
        SWEEP_UP_TO_N = 2'b00,
        SWEEP_FROM_N = 2'b01,
        SWEEP_REPEAT_N = 2'b10,
        SWEEP_ONCE_N = 2'b11
    } sweep_mode_t;

    // Settings held by the command registers
    typedef struct packed {
        logic [3:0] channel_code;
        sweep_mode_t sweep_mode;
        logic temperature_request;
        logic [1:0] clocking_mode;
        logic [1:0] reference_choice;
        logic [1:0] pair_register_select;
        logic averaging_enable;
        logic [1:0] average_depth;
        logic [1:0] repeat_count;
        logic [7:0] unipolar_pair_bits;
        logic [7:0] bipolar_pair_bits;
    } settings_t;

    // Plan of one requested scan
    typedef struct packed {
        logic [15:0] channel_mask;
        logic [15:0] bipolar_mask;
        logic [5:0] result_count;
        logic [5:0] samples_per_result;
        logic temperature_first;
    } scan_plan_t;

endpackage

// ===== design/adc_cmd_regs.svh
`ifndef ADC_CMD_REGS_SVH
`define ADC_CMD_REGS_SVH

// Command byte leading-one prefixes
`define CMD_CONV_BIT 7
`define CMD_SETUP_PREFIX 2'b01
`define CMD_AVG_PREFIX 3'b001
`define CMD_RESET_PREFIX 4'b0001

// Field positions inside command bytes
`define RESET_FIFO_BIT 3
`define PAIR_SEL_ACTIVE_BIT 1
`define PAIR_SEL_BIPOLAR_BIT 0

// Register reset values
`define SETUP_RESET 8'h20
`define ZERO_RESET 8'h00

// Samples per result for each average depth code
`define AVG_DEPTH_0 6'h04
`define AVG_DEPTH_1 6'h08
`define AVG_DEPTH_2 6'h10
`define AVG_DEPTH_3 6'h20
`define AVG_OFF_SAMPLES 6'h01

// Results requested in repeated single-channel scans
`define REPEAT_COUNT_0 6'h04
`define REPEAT_COUNT_1 6'h08
`define REPEAT_COUNT_2 6'h0C
`define REPEAT_COUNT_3 6'h10

`endif

// ===== design/adc_command_byte_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_cmd_regs.svh"

// Overview of operation
// - A byte with top bit set is a conversion command: channel, sweep, temperature.
// - Setup bits 5 and 4 select the clocking mode.
// - Setup bits 3 and 2 select the reference mode.
// - The channel code is a plain binary index from input 0 to 15.
// - Sweep 00 converts 0 up to N; sweep 01 converts N up to the top.
// - Sweep 10 repeats channel N per repeat count; sweep 11 converts N once.
// - Sweeps 00/01 give one result per single channel or pair, plus temperature.
// - A temperature request adds one measurement, placed first in the scan.
// - Scans start on a conversion write in modes 1x, pin low pulse in 0x.
// - Channels serving as start pin or reference input are skipped.
// - For a differential pair the channel code lsb is ignored; one result.
// - A top pair losing a pin to start or reference is dropped entirely.
// - Select codes 10/11 make the next byte in the frame a pair byte.
// - Select codes 00/01 write no pair register; next byte is a command.
// - A pair marked both unipolar and bipolar runs unipolar.
// - Unipolar results are straight binary, bipolar results two's complement.
// - Averaging reaches 32 samples; repeat count is independent of depth.
// - Averaging applies in every sweep only while the averaging enable bit is set.
// - Clocking mode 11 disables averaging regardless of the register.
// - Reset command with bit set clears FIFO; with bit clear restores defaults.
// - Registers power up zero except clocking mode, which comes up as 10.
// - Pair register bit 7 is pair 0/1 down to bit 0 for 14/15.
// - Bytes arrive msb first, data sampled on rising serial clock edges.
module adc_command_byte_decoder #(
    parameter int CHANNELS = 16
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic convert_start_pin_n,
    output var adc_cmd_pkg::settings_t settings,
    output var adc_cmd_pkg::scan_plan_t scan_plan,
    output logic scan_start,
    output logic fifo_clear
);
    import adc_cmd_pkg::*;

    // Serial link domain, clocked by the host's serial clock; that clock
    // stands still between frames, so a byte is handed over the moment its
    // eighth bit is sampled, never on a later edge
    logic [2:0] bit_count;
    logic [6:0] shift_bits;
    logic frame_first;
    logic [8:0] link_word;
    logic link_toggle;

    // Frame logic is cleared while chip select is high, so nothing relies
    // on serial clock edges outside a frame
    // and a cut frame leaves no half byte behind for the next one
    wire frame_idle = cs_n | ~nrst;
    wire byte_done = (bit_count == 3'h7);

    // Bit counter and shifter, msb first on rising edges
    always_ff @(posedge sclk or posedge frame_idle) begin
        if (frame_idle) begin
            bit_count <= 3'h0;
            shift_bits <= 7'h00;
            frame_first <= 1'b1;
        end else begin
            bit_count <= bit_count + 3'h1;
            shift_bits <= {shift_bits[5:0], din};
            if (byte_done) begin
                frame_first <= 1'b0;
            end
        end
    end

    // Completed byte with its first-in-frame flag; held until the next byte
    // The flag lets the decoder tell a pair byte from a fresh command,
    // since a pair byte is only valid inside the setup byte's own frame
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            link_word <= 9'h000;
            link_toggle <= 1'b0;
        end else if (byte_done) begin
            link_word <= {frame_first, shift_bits, din};
            link_toggle <= ~link_toggle;
        end
    end

    // Crossing into the system clock domain: only the toggle and the start
    // pin pass synchronisers; the held word is read without one because it
    // stays put for a whole byte time after the toggle has moved
    logic toggle_meta;
    logic toggle_sync;
    logic toggle_seen;
    logic start_meta;
    logic start_sync;
    logic start_seen;

    // Toggle handshake for byte events and two-flop sync for the start pin
    // The third flop of each chain only remembers the last synced level
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            toggle_meta <= 1'b0;
            toggle_sync <= 1'b0;
            toggle_seen <= 1'b0;
            start_meta <= 1'b1;
            start_sync <= 1'b1;
            start_seen <= 1'b1;
        end else begin
            toggle_meta <= link_toggle;
            toggle_sync <= toggle_meta;
            toggle_seen <= toggle_sync;
            start_meta <= convert_start_pin_n;
            start_sync <= start_meta;
            start_seen <= start_sync;
        end
    end

    // The held word is stable for a whole byte time after the toggle moves
    // A byte takes at least eight serial periods, far longer than the sync
    wire byte_arrived = toggle_sync ^ toggle_seen;
    wire [7:0] rx_byte = link_word[7:0];
    wire rx_first = link_word[8];
    wire start_pulse = start_seen & ~start_sync;

    // Command registers, written only from the system clock domain so that a
    // soft reset and a byte write can never race each other across clocks
    // Each byte is steered to exactly one register or to none at all
    logic [7:0] conversion_command;
    logic [7:0] setup_configuration;
    logic [7:0] averaging_control;
    logic [7:0] unipolar_pair_enable;
    logic [7:0] bipolar_pair_enable;
    logic [1:0] pair_pending;

    // Pair byte must follow the setup byte inside the same frame
    wire take_pair = byte_arrived & pair_pending[1] & ~rx_first;
    wire take_cmd = byte_arrived & ~take_pair;

    // Leading-one decode of the upper nibble; all-zero nibble hits nothing
    // A pair byte is never decoded, whatever its top bits happen to be
    wire hit_conv = take_cmd & rx_byte[`CMD_CONV_BIT];
    wire hit_setup = take_cmd & (rx_byte[7:6] == `CMD_SETUP_PREFIX);
    wire hit_avg = take_cmd & (rx_byte[7:5] == `CMD_AVG_PREFIX);
    wire hit_reset = take_cmd & (rx_byte[7:4] == `CMD_RESET_PREFIX);

    // Reset command actions
    // The fifo clear is only a pulse; the fifo itself lives outside
    wire soft_reset = hit_reset & ~rx_byte[`RESET_FIFO_BIT];
    wire fifo_reset = hit_reset & rx_byte[`RESET_FIFO_BIT];

    // Pair register writes steered by the pending select code
    // Bit 0 of the select code chooses bipolar over unipolar
    wire write_unipolar = take_pair & ~pair_pending[0];
    wire write_bipolar = take_pair & pair_pending[0];

    // Select codes 10/11 arm a pair byte, 00/01 leave nothing pending
    // The armed code lives for exactly one following byte
    wire [1:0] setup_pending = rx_byte[`PAIR_SEL_ACTIVE_BIT] ?
        {1'b1, rx_byte[`PAIR_SEL_BIPOLAR_BIT]} : 2'b00;

    // Conversion, setup and averaging registers
    // A soft reset wins over any write in the same cycle; both come from
    // one byte, so they never actually meet
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            conversion_command <= `ZERO_RESET;
            setup_configuration <= `SETUP_RESET;
            averaging_control <= `ZERO_RESET;
        end else if (soft_reset) begin
            conversion_command <= `ZERO_RESET;
            setup_configuration <= `SETUP_RESET;
            averaging_control <= `ZERO_RESET;
        end else begin
            if (hit_conv) begin
                conversion_command <= rx_byte;
            end
            if (hit_setup) begin
                setup_configuration <= rx_byte;
            end
            if (hit_avg) begin
                averaging_control <= rx_byte;
            end
        end
    end

    // Pair registers and the pending pair byte
    // A soft reset also drops a pair byte that the host has armed but
    // not yet sent
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            unipolar_pair_enable <= `ZERO_RESET;
            bipolar_pair_enable <= `ZERO_RESET;
            pair_pending <= 2'b00;
        end else if (soft_reset) begin
            unipolar_pair_enable <= `ZERO_RESET;
            bipolar_pair_enable <= `ZERO_RESET;
            pair_pending <= 2'b00;
        end else begin
            if (write_unipolar) begin
                unipolar_pair_enable <= rx_byte;
            end
            if (write_bipolar) begin
                bipolar_pair_enable <= rx_byte;
            end
            if (hit_setup) begin
                pair_pending <= setup_pending;
            end else if (byte_arrived) begin
                pair_pending <= 2'b00;
            end
        end
    end

    // Field views of the registers
    // Pure renaming of register bits, kept here so the planner reads clearly
    wire [3:0] chan_n = conversion_command[6:3];
    wire [1:0] sweep = conversion_command[2:1];
    wire temp_request = conversion_command[0];
    wire [1:0] clocking_mode = setup_configuration[5:4];
    wire [1:0] reference_mode = setup_configuration[3:2];
    wire avg_enable_bit = averaging_control[4];
    wire [1:0] depth_code = averaging_control[3:2];
    wire [1:0] repeat_code = averaging_control[1:0];

    // Pins taken over by the start input or the negative reference
    // Modes 0x lend the top pin to the start input; reference 11 the next
    wire start_pin_mode = ~clocking_mode[1];
    wire ref_pin_mode = (reference_mode == 2'b11);

    // Scan planning: pure decode of the registers; nothing here is stored
    // until a start is requested, so a register write between scans only
    // affects the next plan
    logic [15:0] want;
    logic [15:0] bip;

    // Per-channel membership of the requested scan
    for (genvar c = 0; c < 16; c++) begin : g_chan
        // Fixed facts about this channel: its pair, whether the part has it
        // and whether the start or reference input may take its pin
        localparam int PAIR = c / 2;
        localparam bit ODD = (c % 2) == 1;
        localparam bit EXISTS = c < CHANNELS;
        localparam bit START_PIN = c == (CHANNELS - 1);
        localparam bit REF_PIN = c == (CHANNELS - 2);
        localparam bit PAIR_START = (2 * PAIR + 1) == (CHANNELS - 1);
        localparam bit PAIR_REF = (2 * PAIR) == (CHANNELS - 2);
        localparam logic [3:0] CH = 4'(c);
        localparam logic [3:0] EVEN_CH = 4'(2 * PAIR);
        localparam logic [3:0] ODD_CH = 4'(2 * PAIR + 1);

        // Bit 7 is pair 0/1, descending to bit 0 for pair 14/15
        wire uni_bit = unipolar_pair_enable[7 - PAIR];
        wire bi_bit = bipolar_pair_enable[7 - PAIR];
        wire pair_diff = uni_bit | bi_bit;

        // Range tests; a pair ignores the channel code lsb
        // A pair counts as inside the range when any of its pins is
        wire up_to = pair_diff ? (EVEN_CH <= chan_n) : (CH <= chan_n);
        wire from_n = pair_diff ? (ODD_CH >= chan_n) : (CH >= chan_n);
        wire only_n = pair_diff ? (EVEN_CH[3:1] == chan_n[3:1]) : (CH == chan_n);
        wire in_range = (sweep == SWEEP_UP_TO_N) ? up_to :
                        (sweep == SWEEP_FROM_N) ? from_n : only_n;

        // Skips for reassigned pins
        wire single_skip = (START_PIN & start_pin_mode) | (REF_PIN & ref_pin_mode);
        wire pair_skip = (PAIR_START & start_pin_mode) | (PAIR_REF & ref_pin_mode);

        // A pair keeps only its even pin; a single keeps itself unless lent out
        wire keep_pair = ~ODD & ~pair_skip;
        wire keep_single = ~single_skip;
        wire keep = pair_diff ? keep_pair : keep_single;

        // One result per single channel, or one on the even pin of a pair
        assign want[c] = EXISTS & in_range & keep;
        assign bip[c] = want[c] & pair_diff & bi_bit & ~uni_bit;
    end

    // Number of set bits in a channel mask
    // Plain ripple of adders; sixteen bits is small enough
    function automatic logic [5:0] count_ones(input logic [15:0] bits);
        logic [5:0] total;
        total = 6'h00;
        for (int i = 0; i < 16; i++) begin
            total = total + {5'h00, bits[i]};
        end
        return total;
    endfunction

    wire [5:0] channel_results = count_ones(want);

    // Repeat count for sweep 10, independent of averaging depth
    // Counts per code are a choice of this block, held in the header
    wire [5:0] repeat_results = (repeat_code == 2'b00) ? `REPEAT_COUNT_0 :
                                (repeat_code == 2'b01) ? `REPEAT_COUNT_1 :
                                (repeat_code == 2'b10) ? `REPEAT_COUNT_2 :
                                `REPEAT_COUNT_3;

    // Results per scan by sweep mode
    // Sweep 10 with no convertible channel gives no channel results
    wire [5:0] sweep_results = (sweep == SWEEP_REPEAT_N && channel_results != 6'h00) ?
                               repeat_results : channel_results;

    // Temperature adds one result ahead of the channel results
    // The sum cannot overflow: at most sixteen results plus one
    wire [5:0] total_results = sweep_results + {5'h00, temp_request};

    // Averaging depth, gated by enable bit and clocking mode 11
    // Averaging off means one sample per result, not zero
    wire averaging_active = avg_enable_bit & (clocking_mode != 2'b11);
    wire [5:0] depth_samples = (depth_code == 2'b00) ? `AVG_DEPTH_0 :
                               (depth_code == 2'b01) ? `AVG_DEPTH_1 :
                               (depth_code == 2'b10) ? `AVG_DEPTH_2 :
                               `AVG_DEPTH_3;
    wire [5:0] samples = averaging_active ? depth_samples : `AVG_OFF_SAMPLES;

    // Scan request: serial write in modes 1x, start pin pulse in modes 0x
    wire conv_start = hit_conv & clocking_mode[1];
    wire pin_start = start_pulse & start_pin_mode;

    // Next plan built from the registers as they stand
    // It is only sampled on a request, so it may settle freely meanwhile
    scan_plan_t next_plan;
    assign next_plan.channel_mask = want;
    assign next_plan.bipolar_mask = bip;
    assign next_plan.result_count = total_results;
    assign next_plan.samples_per_result = samples;
    assign next_plan.temperature_first = temp_request;

    logic plan_request;

    // Request is delayed one cycle so the plan sees the new command byte
    // Without the delay a start by command would plan with the previous
    // channel and sweep, since the register updates on the same edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            plan_request <= 1'b0;
        end else begin
            plan_request <= conv_start | pin_start;
        end
    end

    // Plan latch and start pulse
    // The plan and its strobe leave on the same edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scan_plan <= '0;
            scan_start <= 1'b0;
        end else begin
            scan_start <= plan_request;
            if (plan_request) begin
                scan_plan <= next_plan;
            end
        end
    end

    // One-cycle FIFO clear pulse
    // Registered so the output comes straight from a flip-flop
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fifo_clear <= 1'b0;
        end else begin
            fifo_clear <= fifo_reset;
        end
    end

    // Settings view, taken straight from the registers
    // Each field is a wire onto a register bit, so it follows a write at once
    assign settings.channel_code = chan_n;
    assign settings.sweep_mode = sweep_mode_t'(sweep);
    assign settings.temperature_request = temp_request;
    assign settings.clocking_mode = clocking_mode;
    assign settings.reference_choice = reference_mode;
    assign settings.pair_register_select = setup_configuration[1:0];
    assign settings.averaging_enable = avg_enable_bit;
    assign settings.average_depth = depth_code;
    assign settings.repeat_count = repeat_code;
    assign settings.unipolar_pair_bits = unipolar_pair_enable;
    assign settings.bipolar_pair_bits = bipolar_pair_enable;

endmodule

`default_nettype wire

// ===== tb/adc_cmd_properties.sv
`timescale 1ns/100ps
`default_nettype none
module adc_cmd_properties #(
    parameter int CHANNELS = 16
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic convert_start_pin_n,
    input wire adc_cmd_pkg::settings_t settings,
    input wire adc_cmd_pkg::scan_plan_t scan_plan,
    input wire logic scan_start,
    input wire logic fifo_clear
);
    import adc_cmd_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // Start and clear strobes last exactly one cycle
    start_pulse_a: assert property (scan_start |=> !scan_start)
        else $error("scan start longer than one cycle");
    clear_pulse_a: assert property (fifo_clear |=> !fifo_clear)
        else $error("fifo clear longer than one cycle");
    // The plan only moves together with a start
    plan_hold_a: assert property (!scan_start |-> $stable(scan_plan))
        else $error("scan plan changed without a start");
    // Samples per result follow the averaging settings
    avg_off_a: assert property (scan_start && !settings.averaging_enable
        |-> scan_plan.samples_per_result == 6'h01)
        else $error("averaging applied while disabled");
    ext_clock_a: assert property (scan_start && settings.clocking_mode == 2'b11
        |-> scan_plan.samples_per_result == 6'h01)
        else $error("averaging applied in external clock mode");
    avg_depth_a: assert property (scan_start && settings.averaging_enable
        && settings.clocking_mode != 2'b11
        |-> scan_plan.samples_per_result == (6'h04 << settings.average_depth))
        else $error("wrong samples per result");
    // Bipolar results sit on converted even channels only
    bipolar_mask_a: assert property (scan_start |-> ((scan_plan.bipolar_mask
        & ~scan_plan.channel_mask) | (scan_plan.bipolar_mask & 16'hAAAA)) == 16'h0000)
        else $error("bipolar mask outside converted pairs");
    // Pins lent to start or reference are never converted
    start_pin_a: assert property (scan_start && !settings.clocking_mode[1]
        |-> !scan_plan.channel_mask[CHANNELS-1])
        else $error("start pin channel converted");
    ref_pin_a: assert property (scan_start && settings.reference_choice == 2'b11
        |-> !scan_plan.channel_mask[CHANNELS-2])
        else $error("reference pin channel converted");
    temp_first_a: assert property (scan_start
        |-> scan_plan.temperature_first == settings.temperature_request)
        else $error("temperature flag not carried into plan");
    once_only_a: assert property (scan_start && settings.sweep_mode == SWEEP_ONCE_N
        |-> $onehot0(scan_plan.channel_mask)
        && scan_plan.result_count == {5'h00, $onehot(scan_plan.channel_mask)}
            + {5'h00, settings.temperature_request})
        else $error("single conversion plan wrong");
endmodule
bind adc_command_byte_decoder adc_cmd_properties #(.CHANNELS(CHANNELS)) i_props (
    .clock(clock), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .convert_start_pin_n(convert_start_pin_n), .settings(settings),
    .scan_plan(scan_plan), .scan_start(scan_start), .fifo_clear(fifo_clear));
`default_nettype wire

// ===== tb/serial_host.sv
`timescale 1ns/100ps
`default_nettype none
module serial_host (
    output logic sclk,
    output logic cs_n,
    output logic din
);
    // Idle bus: clock parked low, chip not selected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // One frame of one or two bytes, 48 ns serial clock, msb first
    task automatic send(input logic [7:0] b0, input logic [7:0] b1, input bit two);
        logic [15:0] w;
        int n;
        w = {b0, b1};
        n = two ? 16 : 8;
        cs_n = 1'b0;
        #24;
        for (int i = 0; i < n; i++) begin
            din = w[15-i];
            #24;
            sclk = 1'b1;
            #24;
            sclk = 1'b0;
        end
        #24;
        cs_n = 1'b1;
        // Released line shows the inverse of its last bit
        din = ~din;
        // Chip select stays high a full serial period before any next frame
        #48;
    endtask
    // Channel codes sent stay below the part's channel count
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import adc_cmd_pkg::*;
    logic clock, nrst, pin_n;
    wire logic sclk, cs_n, din;
    settings_t settings, rst_exp, snap;
    scan_plan_t scan_plan;
    logic scan_start, fifo_clear;
    int fail_count, checks, starts, clears, s0;

    // 20 MHz system clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    serial_host i_host (.sclk(sclk), .cs_n(cs_n), .din(din));
    adc_command_byte_decoder #(.CHANNELS(16)) i_dut (.clock(clock), .nrst(nrst),
        .sclk(sclk), .cs_n(cs_n), .din(din), .convert_start_pin_n(pin_n),
        .settings(settings), .scan_plan(scan_plan), .scan_start(scan_start),
        .fifo_clear(fifo_clear));

    // Count strobes as they appear
    always @(posedge clock) begin
        if (scan_start === 1'b1) starts++;
        if (fifo_clear === 1'b1) clears++;
    end

    task automatic compare(input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (fail_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Frame then let the register update settle
    task automatic put(input logic [7:0] b0, input logic [7:0] b1, input bit two);
        i_host.send(b0, b1, two);
        repeat (6) @(posedge clock);
    endtask

    // Bounded wait for one start strobe, then check the plan
    task automatic plan(input logic [15:0] m, input logic [15:0] b, input logic [5:0] c,
        input logic [5:0] s, input logic t);
        for (int i = 0; i < 20 && starts == s0; i++) @(negedge clock);
        if (starts == s0) begin
            fail_count++;
            tally_and_finish;
        end else begin
            compare(scan_plan.channel_mask, m);
            compare(scan_plan.bipolar_mask, b);
            compare(scan_plan.result_count, c);
            compare(scan_plan.samples_per_result, s);
            compare(scan_plan.temperature_first, t);
        end
    endtask

    task automatic conv(input logic [7:0] cmd, input logic [15:0] m, input logic [15:0] b,
        input logic [5:0] c, input logic [5:0] s);
        s0 = starts;
        i_host.send(cmd, 8'h00, 0);
        plan(m, b, c, s, cmd[0]);
    endtask

    task automatic pulse;
        @(posedge clock) pin_n <= 1'b0;
        repeat (3) @(posedge clock);
        pin_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        tally_and_finish;
    end

    // Main sequence
    initial begin
        nrst = 1'b0;
        pin_n = 1'b1;
        fail_count = 0;
        checks = 0;
        starts = 0;
        clears = 0;
        rst_exp = '0;
        rst_exp.clocking_mode = 2'b10;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        compare(settings, rst_exp);
        compare(scan_plan, '0);
        put(8'h7E, 8'h81, 1);
        compare(settings.clocking_mode, 2'b11);
        compare(settings.reference_choice, 2'b11);
        compare(settings.unipolar_pair_bits, 8'h81);
        put(8'h61, 8'h3D, 1);
        compare(settings.unipolar_pair_bits, 8'h81);
        compare({settings.averaging_enable, settings.average_depth,
            settings.repeat_count}, 5'b11101);
        put(8'h62, 8'h40, 1);
        compare(settings.unipolar_pair_bits, 8'h40);
        snap = settings;
        put(8'h0F, 8'h00, 0);
        compare(settings, snap);
        conv(8'hA9, 16'h0037, 16'h0000, 6'd6, 6'd32);
        conv(8'h9A, 16'hFFF4, 16'h0000, 6'd13, 6'd32);
        conv(8'h9C, 16'h0004, 16'h0000, 6'd8, 6'd32);
        conv(8'hBE, 16'h0080, 16'h0000, 6'd1, 6'd32);
        s0 = starts;
        pulse;
        compare(starts, s0);
        put(8'h63, 8'h60, 1);
        compare(settings.bipolar_pair_bits, 8'h60);
        conv(8'hF8, 16'hFFD7, 16'h0010, 6'd14, 6'd32);
        put(8'h7C, 8'h00, 0);
        conv(8'hF8, 16'hBFD7, 16'h0010, 6'd13, 6'd1);
        put(8'h42, 8'h41, 1);
        s0 = starts;
        put(8'hF8, 8'h00, 0);
        repeat (10) @(posedge clock);
        compare(starts, s0);
        pulse;
        plan(16'h3FD7, 16'h0010, 6'd12, 6'd32, 1'b0);
        put(8'h52, 8'h41, 1);
        s0 = starts;
        pulse;
        plan(16'h3FD7, 16'h0010, 6'd12, 6'd32, 1'b0);
        s0 = clears;
        put(8'h18, 8'h00, 0);
        compare(clears, s0 + 1);
        compare(settings.unipolar_pair_bits, 8'h41);
        put(8'h10, 8'h00, 0);
        compare(settings, rst_exp);
        conv(8'h80, 16'h0001, 16'h0000, 6'd1, 6'd1);
        tally_and_finish;
    end
endmodule
`default_nettype wire
